// file: hdl/fspp_pkg.sv
`default_nettype none

package fspp_pkg;

   // register word indices on the bus; byte address is four times the index
   localparam logic [7:0]  FSPP_REG_CTRL      = 8'h37;
   localparam logic [7:0]  FSPP_REG_ADDR      = 8'h40;
   localparam logic [7:0]  FSPP_REG_DATA      = 8'h41;
   localparam logic [7:0]  FSPP_REG_GUARD     = 8'h42;
   localparam logic [7:0]  FSPP_REG_OPTION    = 8'h43;

   // control register fields
   localparam int          FSPP_CTRL_PGM_BIT  = 0;
   localparam int          FSPP_CTRL_SER_BIT  = 1;
   localparam int          FSPP_CTRL_MER_BIT  = 2;
   localparam int          FSPP_CTRL_UNLK_BIT = 5;
   localparam int          FSPP_CTRL_REF_BIT  = 6;
   localparam int          FSPP_CTRL_BUSY_BIT = 7;
   localparam logic [7:0]  FSPP_CTRL_RESET    = 8'h00;

   // option register field
   localparam int          FSPP_OPT_PROT_BIT  = 0;
   localparam logic        FSPP_OPT_RESET     = 1'b0;

   // access guard keys, written in this order just before a control write
   localparam logic [7:0]  FSPP_GUARD_KEY1    = 8'ha5;
   localparam logic [7:0]  FSPP_GUARD_KEY2    = 8'h5a;

   // array geometry
   localparam logic [7:0]  FSPP_ERASED_BYTE   = 8'hff;
   localparam logic [15:0] FSPP_SECT0_BASE    = 16'hf000;
   localparam logic [15:0] FSPP_SECT1_BASE    = 16'he000;
   localparam logic [15:0] FSPP_TOP_ADDR      = 16'hffff;

   // serial link framing
   localparam int          FSPP_LINK_ADDR_BITS = 16;
   localparam int          FSPP_LINK_DATA_BITS = 8;

   typedef enum logic [1:0] {
      FSPP_ST_IDLE  = 2'b00,
      FSPP_ST_PROG  = 2'b01,
      FSPP_ST_ERASE = 2'b10
   } fspp_state_t;

endpackage

`default_nettype wire

// file: hdl/fspp_sync.sv
`default_nettype none

// two-flop synchroniser for pins from outside the clk_sys domain
module fspp_sync #(
   parameter int WIDTH = 1
) (
   // clock and reset
   input  wire logic             clk_sys,
   input  wire logic             rst_b,
   // asynchronous in, synchronised out
   input  wire logic [WIDTH-1:0] d,
   output logic      [WIDTH-1:0] q
);

   logic [WIDTH-1:0] meta;

   // first stage feeds only the second stage
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end

endmodule

`default_nettype wire

// file: hdl/fspp_top.sv
// The implementer's own choice: the Avalon-MM register port.
`default_nettype none

module fspp_top
   import fspp_pkg::*;
#(
   parameter int FLASH_KB = 32
) (
   // clock and reset
   input  wire logic        clk_sys,
   input  wire logic        rst_b,
   // avalon-mm slave, word addressed
   input  wire logic [7:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic      [31:0] avs_readdata,
   output logic             avs_waitrequest,
   // in-circuit link pins
   input  wire logic        incircuit_serial_clock,
   input  wire logic        incircuit_serial_data_in,
   output logic             incircuit_serial_data_out,
   output logic             incircuit_serial_data_oe,
   input  wire logic        programming_voltage_select,
   // status towards the application
   output logic             app_pins_available,
   output logic             readout_protected,
   output logic             flash_busy
);

   localparam int          FLASH_BYTES = FLASH_KB * 1024;
   localparam int          AW          = $clog2(FLASH_BYTES);
   localparam logic [15:0] FLASH_BASE  = 16'(32'h10000 - FLASH_BYTES);

   // only the documented array sizes map onto the sector layout
   generate
      if (FLASH_KB != 4 && FLASH_KB != 8 && FLASH_KB != 16 && FLASH_KB != 32) begin : g_bad_size
         $error("fspp_top: FLASH_KB must be 4, 8, 16 or 32");
      end
   endgenerate

   typedef struct packed {
      logic                         wait_r;
      logic [31:0]                  rdata;
      logic [15:0]                  addr;
      logic [7:0]                   wdata;
      logic                         guard1;
      logic                         unlocked;
      logic                         refused;
      logic                         prot;
      logic                         unprot_pend;
      fspp_state_t                  state;
      logic [15:0]                  ecnt;
      logic [15:0]                  eend;
      logic                         sclk_prev;
      logic                         pins_free;
      logic [FSPP_LINK_ADDR_BITS-1:0] lsh;
      logic [4:0]                   lcnt;
      logic [FSPP_LINK_DATA_BITS-1:0] osh;
      logic [3:0]                   ocnt;
      logic                         dout;
      logic                         doe;
      logic                         busy;
   } fspp_regs_t;

   fspp_regs_t s;
   fspp_regs_t next_s;

   logic [7:0]    mem [FLASH_BYTES];
   logic          mem_we;
   logic [AW-1:0] mem_wa;
   logic [7:0]    mem_wd;

   logic [2:0]    pin_q;
   logic          sclk;
   logic          sdat;
   logic          icc_mode;

   // sector number of an absolute address
   function automatic logic [1:0] sector_of(input logic [15:0] a);
      if (a >= FSPP_SECT0_BASE) begin
         return 2'd0;
      end else if (a >= FSPP_SECT1_BASE) begin
         return 2'd1;
      end
      return 2'd2;
   endfunction

   // the configured size decides which sectors exist
   function automatic logic present(input logic [15:0] a);
      return a >= FLASH_BASE;
   endfunction

   function automatic logic [AW-1:0] index_of(input logic [15:0] a);
      logic [15:0] off;
      off = a - FLASH_BASE;
      return off[AW-1:0];
   endfunction

   // first address of a sector; only sector 2 returns the array base, the caller clips the others
   function automatic logic [15:0] sector_start(input logic [1:0] sec);
      unique case (sec)
         2'd0:    return FSPP_SECT0_BASE;
         2'd1:    return FSPP_SECT1_BASE;
         default: return FLASH_BASE;
      endcase
   endfunction

   function automatic logic [15:0] sector_end(input logic [1:0] sec);
      unique case (sec)
         2'd0:    return FSPP_TOP_ADDR;
         2'd1:    return FSPP_SECT0_BASE - 16'h0001;
         default: return FSPP_SECT1_BASE - 16'h0001;
      endcase
   endfunction

   // pins arrive from the tool's domain
   fspp_sync #(
      .WIDTH (3)
   ) u_pin_sync (
      .clk_sys (clk_sys),
      .rst_b   (rst_b),
      .d       ({programming_voltage_select, incircuit_serial_data_in, incircuit_serial_clock}),
      .q       (pin_q)
   );

   assign sclk     = pin_q[0];
   assign sdat     = pin_q[1];
   assign icc_mode = pin_q[2];

   // next state: bus slave, guard, operation sequencer, serial link
   always_comb begin
      logic        take;
      logic        act_wr;
      logic        refuse_evt;
      logic        clear_ref;
      logic        rise;
      logic        fall;
      logic [1:0]  sec;
      logic        sec_ok;
      logic [15:0] laddr;
      logic [7:0]  wb;
      take       = 1'b0;
      act_wr     = 1'b0;
      refuse_evt = 1'b0;
      clear_ref  = 1'b0;
      rise       = 1'b0;
      fall       = 1'b0;
      sec        = 2'd0;
      sec_ok     = 1'b0;
      laddr      = '0;
      wb         = avs_writedata[7:0];
      next_s     = s;
      mem_we     = 1'b0;
      mem_wa     = '0;
      mem_wd     = '0;

      // one wait cycle, then the answer; a write acts when waitrequest is seen low
      take          = (avs_read || avs_write) && s.wait_r;
      act_wr        = avs_write && !s.wait_r;
      next_s.wait_r = !take;

      if (take && avs_read) begin
         next_s.rdata = '0;
         unique case (avs_address)
            FSPP_REG_CTRL: begin
               next_s.rdata[FSPP_CTRL_BUSY_BIT] = (s.state != FSPP_ST_IDLE);
               next_s.rdata[FSPP_CTRL_REF_BIT]  = s.refused;
               next_s.rdata[FSPP_CTRL_UNLK_BIT] = s.unlocked;
            end
            FSPP_REG_ADDR:   next_s.rdata[15:0] = s.addr;
            FSPP_REG_DATA:   next_s.rdata[7:0]  = present(s.addr) ? mem[index_of(s.addr)] : 8'h00;
            FSPP_REG_GUARD:  next_s.rdata[0]    = s.guard1;
            FSPP_REG_OPTION: next_s.rdata[FSPP_OPT_PROT_BIT] = s.prot;
            default:         next_s.rdata = '0;
         endcase
      end

      // target sector of the current address
      sec    = sector_of(s.addr);
      sec_ok = present(s.addr) && !(sec == 2'd0 && !icc_mode);

      if (act_wr) begin
         unique case (avs_address)
            FSPP_REG_ADDR: next_s.addr  = avs_writedata[15:0];
            FSPP_REG_DATA: next_s.wdata = wb;
            FSPP_REG_GUARD: begin
               // any other value or order drops the guard again
               next_s.guard1   = (wb == FSPP_GUARD_KEY1);
               next_s.unlocked = s.guard1 && (wb == FSPP_GUARD_KEY2);
            end
            FSPP_REG_CTRL: begin
               clear_ref       = wb[FSPP_CTRL_REF_BIT];
               next_s.unlocked = 1'b0;
               next_s.guard1   = 1'b0;
               if (wb[FSPP_CTRL_MER_BIT] || wb[FSPP_CTRL_SER_BIT] || wb[FSPP_CTRL_PGM_BIT]) begin
                  if (!s.unlocked || s.state != FSPP_ST_IDLE || s.prot) begin
                     refuse_evt = 1'b1;
                  end else if (wb[FSPP_CTRL_MER_BIT]) begin
                     // the whole array includes sector 0
                     if (icc_mode) begin
                        next_s.ecnt  = FLASH_BASE;
                        next_s.eend  = FSPP_TOP_ADDR;
                        next_s.state = FSPP_ST_ERASE;
                     end else begin
                        refuse_evt = 1'b1;
                     end
                  end else if (!sec_ok) begin
                     refuse_evt = 1'b1;
                  end else if (wb[FSPP_CTRL_SER_BIT]) begin
                     next_s.ecnt  = (sector_start(sec) < FLASH_BASE) ? FLASH_BASE : sector_start(sec);
                     next_s.eend  = sector_end(sec);
                     next_s.state = FSPP_ST_ERASE;
                  end else begin
                     next_s.state = FSPP_ST_PROG;
                  end
               end
            end
            FSPP_REG_OPTION: begin
               next_s.unlocked = 1'b0;
               next_s.guard1   = 1'b0;
               if (!s.unlocked || !icc_mode || s.state != FSPP_ST_IDLE) begin
                  refuse_evt = 1'b1;
               end else if (wb[FSPP_OPT_PROT_BIT]) begin
                  next_s.prot = 1'b1;
               end else if (s.prot) begin
                  // protection only drops after the array is blank
                  next_s.unprot_pend = 1'b1;
                  next_s.ecnt        = FLASH_BASE;
                  next_s.eend        = FSPP_TOP_ADDR;
                  next_s.state       = FSPP_ST_ERASE;
               end
            end
            default: ;
         endcase
      end

      // a refusal in the clearing cycle is kept
      next_s.refused = (s.refused && !clear_ref) || refuse_evt;

      // operation sequencer, one byte per cycle
      unique case (s.state)
         FSPP_ST_IDLE: ;
         FSPP_ST_PROG: begin
            mem_we       = 1'b1;
            mem_wa       = index_of(s.addr);
            mem_wd       = s.wdata;
            next_s.state = FSPP_ST_IDLE;
         end
         FSPP_ST_ERASE: begin
            mem_we = 1'b1;
            mem_wa = index_of(s.ecnt);
            mem_wd = FSPP_ERASED_BYTE;
            if (s.ecnt == s.eend) begin
               next_s.state = FSPP_ST_IDLE;
               if (s.unprot_pend) begin
                  next_s.prot        = 1'b0;
                  next_s.unprot_pend = 1'b0;
               end
            end else begin
               next_s.ecnt = s.ecnt + 16'h0001;
            end
         end
         default: next_s.state = FSPP_ST_IDLE;
      endcase

      // edges of the tool's serial clock, seen through the synchroniser
      next_s.sclk_prev = sclk;
      rise             = sclk && !s.sclk_prev;
      fall             = !sclk && s.sclk_prev;

      // a clock edge or voltage select means the tool is attached
      if (rise || icc_mode) begin
         next_s.pins_free = 1'b0;
      end

      // link: 16 address bits in on rising edges, 8 data bits out on falling edges
      if (!icc_mode) begin
         next_s.lcnt = '0;
         next_s.ocnt = '0;
         next_s.doe  = 1'b0;
      end else begin
         if (rise && !s.doe && s.ocnt == 4'd0) begin
            laddr      = {s.lsh[FSPP_LINK_ADDR_BITS-2:0], sdat};
            next_s.lsh = laddr;
            if (s.lcnt == 5'(FSPP_LINK_ADDR_BITS - 1)) begin
               next_s.lcnt = '0;
               next_s.ocnt = 4'(FSPP_LINK_DATA_BITS);
               // protected parts answer zero so nothing leaves the chip
               next_s.osh  = (s.prot || !present(laddr)) ? 8'h00 : mem[index_of(laddr)];
            end else begin
               next_s.lcnt = s.lcnt + 5'd1;
            end
         end
         if (fall) begin
            if (s.ocnt != 4'd0) begin
               next_s.dout = s.osh[FSPP_LINK_DATA_BITS-1];
               next_s.osh  = {s.osh[FSPP_LINK_DATA_BITS-2:0], 1'b0};
               next_s.ocnt = s.ocnt - 4'd1;
               next_s.doe  = 1'b1;
            end else begin
               next_s.doe  = 1'b0;
            end
         end
      end

      // busy kept as a flop of its own so the status pin is registered
      next_s.busy = (next_s.state != FSPP_ST_IDLE);
   end

   // state register; everything the top drives out comes from here
   always_ff @(posedge clk_sys) begin
      if (!rst_b) begin
         s           <= '0;
         s.wait_r    <= 1'b1;
         s.prot      <= FSPP_OPT_RESET;
         s.state     <= FSPP_ST_IDLE;
         s.pins_free <= 1'b1;
      end else begin
         s <= next_s;
      end
   end

   // array storage; content is undefined until first erased, as on a fresh part
   always_ff @(posedge clk_sys) begin
      if (mem_we) begin
         mem[mem_wa] <= mem_wd;
      end
   end

   assign avs_readdata              = s.rdata;
   assign avs_waitrequest           = s.wait_r;
   assign incircuit_serial_data_out = s.dout;
   assign incircuit_serial_data_oe  = s.doe;
   assign app_pins_available        = s.pins_free;
   assign readout_protected         = s.prot;
   assign flash_busy                = s.busy;

endmodule

`default_nettype wire

// file: tb/fspp_asserts.sv
`default_nettype none

// port-level checks of the flash access block
module fspp_asserts #(
   parameter int FLASH_KB = 32
) (
   // clock and reset
   input wire logic        clk_sys,
   input wire logic        rst_b,
   // register bus
   input wire logic [7:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   // link pins
   input wire logic        incircuit_serial_clock,
   input wire logic        incircuit_serial_data_in,
   input wire logic        incircuit_serial_data_out,
   input wire logic        incircuit_serial_data_oe,
   input wire logic        programming_voltage_select,
   // status
   input wire logic        app_pins_available,
   input wire logic        readout_protected,
   input wire logic        flash_busy
);
   timeunit 1ns;
   timeprecision 1ps;

   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_b);

   // one wait cycle, then the answer, then busy again
   AST_WAIT_ONE: assert property ((avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
      else $error("bus request not answered after one wait cycle");
   AST_WAIT_PULSE: assert property (!avs_waitrequest |=> avs_waitrequest)
      else $error("waitrequest low for more than one cycle");
   AST_UPPER_ZERO: assert property (avs_read && !avs_waitrequest |-> avs_readdata[31:16] == 16'h0000)
      else $error("upper read data bits not zero");
   // link drive only in tool mode; sync delay is three cycles at most
   AST_OE_TOOL: assert property (!programming_voltage_select [*4] |-> !incircuit_serial_data_oe)
      else $error("data line driven in application mode");
   AST_PROT_NO_DATA: assert property (readout_protected && incircuit_serial_data_oe
      |-> !incircuit_serial_data_out)
      else $error("array bit leaked while protected");
   // pins go to the tool and stay there
   AST_PINS_STICKY: assert property (!app_pins_available |=> !app_pins_available)
      else $error("pins returned to application");
   AST_PINS_DROP: assert property ($rose(programming_voltage_select) |-> ##[1:4] !app_pins_available)
      else $error("tool connection not reported");
   // work only starts from a guarded register write
   AST_BUSY_CAUSE: assert property ($rose(flash_busy) |-> $past(avs_write) || $past(avs_write, 2))
      else $error("busy rose without a register write");
   AST_PROT_CLEAR: assert property ($fell(readout_protected) |-> $past(flash_busy))
      else $error("protection dropped without erase");

   COV_BUSY: cover property ($rose(flash_busy));
   COV_LINK: cover property ($rose(incircuit_serial_data_oe));
   COV_PROT: cover property ($fell(readout_protected));
endmodule

bind fspp_top fspp_asserts #(.FLASH_KB(FLASH_KB)) u_fspp_asserts (
   .clk_sys                    (clk_sys),
   .rst_b                      (rst_b),
   .avs_address                (avs_address),
   .avs_read                   (avs_read),
   .avs_write                  (avs_write),
   .avs_writedata              (avs_writedata),
   .avs_readdata               (avs_readdata),
   .avs_waitrequest            (avs_waitrequest),
   .incircuit_serial_clock     (incircuit_serial_clock),
   .incircuit_serial_data_in   (incircuit_serial_data_in),
   .incircuit_serial_data_out  (incircuit_serial_data_out),
   .incircuit_serial_data_oe   (incircuit_serial_data_oe),
   .programming_voltage_select (programming_voltage_select),
   .app_pins_available         (app_pins_available),
   .readout_protected          (readout_protected),
   .flash_busy                 (flash_busy)
);

`default_nettype wire

// file: tb/fspp_tool.sv
`default_nettype none

// programming tool on the far side of the serial link
module fspp_tool (
   // pacing clock
   input  wire logic clk_sys,
   // link pins
   output logic      sclk,
   output logic      tdata,
   output logic      toe,
   output logic      vsel,
   input  wire logic line
);
   timeunit 1ns;
   timeprecision 1ps;

   // clock idles low between frames, data line released
   initial begin
      sclk = 1'b0;
      tdata = 1'b0;
      toe = 1'b0;
      vsel = 1'b0;
   end

   // tool switches the device into or out of link mode first
   task automatic set_sel(input logic v);
      @(posedge clk_sys);
      vsel <= v;
      repeat (8) @(posedge clk_sys);
   endtask

   // 16 address bits out, then 8 data bits back; 8 clk_sys per bit
   task automatic link_read(input logic [15:0] a, output logic [7:0] b);
      b = 8'h00;
      for (int k = 0; k < 25; k++) begin
         @(posedge clk_sys);
         sclk <= 1'b0;
         toe <= (k < 16);
         tdata <= (k < 16) ? a[15 - (k % 16)] : 1'b0;
         repeat (4) @(posedge clk_sys);
         if (k < 24) sclk <= 1'b1;
         repeat (2) @(posedge clk_sys);
         if (k >= 16 && k < 24) b = {b[6:0], line};
         @(posedge clk_sys);
      end
   endtask
endmodule

`default_nettype wire

// file: tb/testbench.sv
`default_nettype none

module testbench
   import fspp_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;

   logic        clk_sys;
   logic        rst_b;
   logic [7:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        sclk, tdata, toe, vsel, dout, doe, line;
   logic        pins_av, prot, busy;
   logic [31:0] rdat;
   logic [7:0]  lb;
   int          fails;
   int          num_checks;

   always #12.5 clk_sys = ~clk_sys;

   // pull-up on the shared data line
   assign line = doe ? dout : (toe ? tdata : 1'b1);

   fspp_top #(.FLASH_KB(8)) u_fspp_top (
      .clk_sys(clk_sys), .rst_b(rst_b), .avs_address(avs_address), .avs_read(avs_read),
      .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
      .avs_waitrequest(avs_waitrequest), .incircuit_serial_clock(sclk),
      .incircuit_serial_data_in(line), .incircuit_serial_data_out(dout),
      .incircuit_serial_data_oe(doe), .programming_voltage_select(vsel),
      .app_pins_available(pins_av), .readout_protected(prot), .flash_busy(busy));

   fspp_tool u_fspp_tool (.clk_sys(clk_sys), .sclk(sclk), .tdata(tdata), .toe(toe), .vsel(vsel), .line(line));

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         fails++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // one bus access; held until waitrequest is sampled low, however long the slave takes
   task automatic acc(input logic wrt, input logic [7:0] a, input logic [31:0] d);
      @(posedge clk_sys);
      avs_address <= a;
      avs_writedata <= d;
      avs_read <= ~wrt;
      avs_write <= wrt;
      // only the watchdog ends a wait that never finishes
      do begin
         @(posedge clk_sys);
      end while (avs_waitrequest !== 1'b0);
      rdat = avs_readdata;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
   endtask

   task automatic unlock();
      acc(1'b1, FSPP_REG_GUARD, 32'h000000a5);
      acc(1'b1, FSPP_REG_GUARD, 32'h0000005a);
   endtask

   // address, data, optional keys, command, wait idle, check and clear refusal
   task automatic cmd(input logic [15:0] a, input logic [7:0] d, input logic [7:0] idx,
                      input logic [7:0] v, input logic unl, input logic ref_e);
      int   n;
      logic bz;
      bz = !ref_e && (idx == FSPP_REG_CTRL || v == 8'h00);
      acc(1'b1, FSPP_REG_ADDR, {16'h0000, a});
      acc(1'b1, FSPP_REG_DATA, {24'h000000, d});
      if (unl) unlock();
      acc(1'b1, idx, {24'h000000, v});
      // an accepted command other than setting protection shows busy on the pin one edge after the write acts
      @(posedge clk_sys);
      chk({31'h0, busy}, {31'h0, bz});
      n = 0;
      do begin
         acc(1'b0, FSPP_REG_CTRL, 32'h0);
         n++;
      end while (rdat[FSPP_CTRL_BUSY_BIT] !== 1'b0 && n < 9000);
      if (n >= 9000) fails++;
      chk({31'h0, rdat[FSPP_CTRL_REF_BIT]}, {31'h0, ref_e});
      unlock();
      acc(1'b1, FSPP_REG_CTRL, 32'h00000040);
   endtask

   task automatic peek(input logic [15:0] a, input logic [7:0] e);
      acc(1'b1, FSPP_REG_ADDR, {16'h0000, a});
      acc(1'b0, FSPP_REG_DATA, 32'h0);
      chk(rdat, {24'h000000, e});
   endtask

   task automatic link(input logic [15:0] a, input logic [7:0] e);
      u_fspp_tool.link_read(a, lb);
      chk({24'h000000, lb}, {24'h000000, e});
   endtask

   task automatic stop_test();
      $display("checks %0d mismatches %0d", num_checks, fails);
      if (fails == 0 && num_checks > 0)
         $display("ALL CHECKS OK");
      else
         $display("CHECKS NOT OK");
      $finish;
   endtask

   // a hang well past the expected two whole erases ends the run
   initial begin
      repeat (90000) @(posedge clk_sys);
      fails++;
      stop_test();
   end

   initial begin
      clk_sys = 1'b0;
      rst_b = 1'b0;
      avs_address = 8'h00;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      fails = 0;
      num_checks = 0;
      // reset only before the tool session, never during it
      repeat (6) @(posedge clk_sys);
      rst_b <= 1'b1;
      acc(1'b0, FSPP_REG_CTRL, 32'h0);
      chk(rdat, {24'h0, FSPP_CTRL_RESET});
      acc(1'b0, FSPP_REG_OPTION, 32'h0);
      chk(rdat, 32'h0);
      acc(1'b1, 8'h10, 32'h000000ff);
      acc(1'b0, 8'h10, 32'h0);
      chk(rdat, 32'h0);
      // first key shows on the guard, both keys in order show as unlocked in control
      acc(1'b1, FSPP_REG_GUARD, {24'h000000, FSPP_GUARD_KEY1});
      acc(1'b0, FSPP_REG_GUARD, 32'h0);
      chk(rdat, 32'h00000001);
      acc(1'b1, FSPP_REG_GUARD, {24'h000000, FSPP_GUARD_KEY2});
      acc(1'b0, FSPP_REG_CTRL, 32'h0);
      chk(rdat, 32'h00000001 << FSPP_CTRL_UNLK_BIT);
      chk({31'h0, pins_av}, 32'h1);
      u_fspp_tool.set_sel(1'b1);
      chk({31'h0, pins_av}, 32'h0);
      // tool mode: whole erase, program, sector erase on both sides of f000
      cmd(16'he000, 8'h00, FSPP_REG_CTRL, 8'h04, 1'b1, 1'b0);
      peek(16'he000, FSPP_ERASED_BYTE);
      peek(16'hffff, FSPP_ERASED_BYTE);
      cmd(16'he005, 8'h3c, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b0);
      cmd(16'hf010, 8'hc3, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b0);
      cmd(16'hefff, 8'h11, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b0);
      peek(16'he005, 8'h3c);
      cmd(16'he000, 8'h00, FSPP_REG_CTRL, 8'h02, 1'b1, 1'b0);
      peek(16'he005, FSPP_ERASED_BYTE);
      peek(16'hf010, 8'hc3);
      cmd(16'hefff, 8'h11, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b0);
      cmd(16'hf000, 8'h00, FSPP_REG_CTRL, 8'h02, 1'b1, 1'b0);
      peek(16'hefff, 8'h11);
      peek(16'hf010, FSPP_ERASED_BYTE);
      // refusals: missing keys, absent sector
      cmd(16'he010, 8'h5a, FSPP_REG_CTRL, 8'h01, 1'b0, 1'b1);
      peek(16'he010, FSPP_ERASED_BYTE);
      cmd(16'hd000, 8'h77, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b1);
      cmd(16'hd000, 8'h00, FSPP_REG_CTRL, 8'h02, 1'b1, 1'b1);
      // application mode: sector 0, whole erase and option closed, others open
      u_fspp_tool.set_sel(1'b0);
      chk({31'h0, pins_av}, 32'h0);
      cmd(16'hf020, 8'h42, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b1);
      cmd(16'hf000, 8'h00, FSPP_REG_CTRL, 8'h02, 1'b1, 1'b1);
      peek(16'hf020, FSPP_ERASED_BYTE);
      cmd(16'he020, 8'h42, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b0);
      cmd(16'he000, 8'h00, FSPP_REG_CTRL, 8'h04, 1'b1, 1'b1);
      peek(16'he020, 8'h42);
      cmd(16'h0000, 8'h00, FSPP_REG_OPTION, 8'h01, 1'b1, 1'b1);
      chk({31'h0, prot}, 32'h0);
      // serial link read, then protection on and off
      u_fspp_tool.set_sel(1'b1);
      cmd(16'hf010, 8'hc3, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b0);
      link(16'hf010, 8'hc3);
      link(16'he020, 8'h42);
      cmd(16'h0000, 8'h00, FSPP_REG_OPTION, 8'h01, 1'b1, 1'b0);
      chk({31'h0, prot}, 32'h1);
      link(16'hf010, 8'h00);
      cmd(16'he030, 8'h01, FSPP_REG_CTRL, 8'h01, 1'b1, 1'b1);
      cmd(16'h0000, 8'h00, FSPP_REG_OPTION, 8'h00, 1'b1, 1'b0);
      chk({31'h0, prot}, 32'h0);
      peek(16'he020, FSPP_ERASED_BYTE);
      peek(16'hf010, FSPP_ERASED_BYTE);
      stop_test();
   end
endmodule

`default_nettype wire
